// [stop1_pkg.sv]
// constants for the stop 1 entry/exit sequencer
// assumes a single 10 MHz clock with synchronous reset
`default_nettype none
package stop1_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam logic [2:0] MODE_SEL_STOP1 = 3'h1;
  localparam int unsigned LINES = 8;
  // oscillator restart times in ns
  localparam int unsigned MULTI_OSC_WAKE_NS = 1200;
  localparam int unsigned HSI_WAKE_NS = 1500;
  // regulator low-power wakeup and flash wakeup in ns
  localparam int unsigned REG_WAKE_NS = 900;
  localparam int unsigned FLASH_WAKE_NS = 700;
  // least times round up to whole cycles
  localparam int unsigned MULTI_OSC_WAKE_CYC =
    (MULTI_OSC_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HSI_WAKE_CYC = (HSI_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REGFL_WAKE_CYC =
    (REG_WAKE_NS + FLASH_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
  typedef enum logic [1:0] {ENTRY_WAIT_INT, ENTRY_WAIT_EVT, ENTRY_EXIT} entry_kind_t;
endpackage : stop1_pkg
`default_nettype wire

// [stop1_wake_timer.sv]
// wakeup latency counter: longer of oscillator restart and regulator plus flash
// assumes load is a one-cycle pulse on the sequencer clock
`default_nettype none
module stop1_wake_timer (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic load,
  input wire logic osc_sel_hsi,
  output logic done
);
  typedef struct packed {
    logic [stop1_pkg::CNT_W-1:0] cnt;
    logic busy;
    logic done;
  } tmr_state_t;
  tmr_state_t st_r;
  tmr_state_t st_nxt;

  function automatic logic [stop1_pkg::CNT_W-1:0] latency(input logic hsi);
    int unsigned osc;
    int unsigned lat;
    osc = hsi ? stop1_pkg::HSI_WAKE_CYC : stop1_pkg::MULTI_OSC_WAKE_CYC;
    lat = (osc > stop1_pkg::REGFL_WAKE_CYC) ? osc : stop1_pkg::REGFL_WAKE_CYC;
    return lat[stop1_pkg::CNT_W-1:0];
  endfunction : latency

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (load) begin
      st_nxt.cnt = latency(osc_sel_hsi);
      st_nxt.busy = 1'b1;
    end else if (st_r.busy) begin
      if (st_r.cnt == 8'h01) begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
        st_nxt.cnt = stop1_pkg::CNT_RST;
      end else begin
        st_nxt.cnt = st_r.cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r <= '0;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign done = st_r.done;
endmodule : stop1_wake_timer
`default_nettype wire

// [stop1_seq.sv]
// stop 1 low-power entry and exit sequencer
// assumes core request pulses and controls come from logic on sys_clk;
// wake lines come from pins and are synchronised here
//
// Overview of operation
// - wait instruction with deep sleep, nothing pending, mode 001 enters stop 1
// - handler return with deep sleep, sleep-after-handler, none pending, mode 001 enters
// - any set line pending or peripheral wake flag makes entry ignored
// - wait-interrupt or handler-return entry wakes on enabled interrupt-mode line
// - wait-event entry with pending-as-event clear wakes only on event-mode line
// - wait-event entry with pending-as-event set wakes on any interrupt-mode line
// - wake latency is longer of oscillator restart and regulator plus flash
`default_nettype none
module stop1_seq (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic wait_interrupt_instr,
  input wire logic wait_event_instr,
  input wire logic handler_return,
  input wire logic deep_sleep_select,
  input wire logic sleep_after_handler,
  input wire logic [2:0] low_power_mode_select,
  input wire logic pending_as_wake_event,
  input wire logic wake_osc_hsi,
  input wire logic [stop1_pkg::LINES-1:0] line_pending_reg1,
  input wire logic periph_wake_flags,
  input wire logic irq_pending,
  input wire logic [stop1_pkg::LINES-1:0] wake_line,
  input wire logic [stop1_pkg::LINES-1:0] line_irq_mode,
  input wire logic [stop1_pkg::LINES-1:0] line_evt_mode,
  input wire logic [stop1_pkg::LINES-1:0] vector_enable,
  output logic in_stop1,
  output logic core_clk_en,
  output logic entry_ignored,
  output logic wake_done,
  output logic service_irq
);
  typedef enum logic [1:0] {ST_RUN, ST_STOP, ST_WAKE} seq_state_t;
  typedef struct packed {
    seq_state_t fsm;
    stop1_pkg::entry_kind_t kind;
    logic sev;
    logic [stop1_pkg::LINES-1:0] sync1;
    logic [stop1_pkg::LINES-1:0] sync2;
    logic irq_wake;
    logic load;
    logic in_stop1;
    logic core_clk_en;
    logic entry_ignored;
    logic wake_done;
    logic service_irq;
  } seq_t;
  seq_t st_r;
  seq_t st_nxt;
  logic tmr_done;

  function automatic logic mode_ok(input logic dsel, input logic [2:0] mode);
    return dsel && (mode == stop1_pkg::MODE_SEL_STOP1);
  endfunction : mode_ok

  logic any_flag;
  logic wfx_req;
  logic ret_req;
  wire logic [stop1_pkg::LINES-1:0] irq_en_hit;
  wire logic [stop1_pkg::LINES-1:0] irq_any_hit;
  wire logic [stop1_pkg::LINES-1:0] evt_hit;
  logic wake_now;

  // per-line wake qualification
  for (genvar g = 0; g < stop1_pkg::LINES; g++) begin : g_line
    assign irq_any_hit[g] = st_r.sync2[g] && line_irq_mode[g];
    assign irq_en_hit[g] = irq_any_hit[g] && vector_enable[g];
    assign evt_hit[g] = st_r.sync2[g] && line_evt_mode[g];
  end : g_line

  always_comb begin
    any_flag = (|line_pending_reg1) || periph_wake_flags || irq_pending;
    wfx_req = (wait_interrupt_instr || wait_event_instr) &&
              mode_ok(deep_sleep_select, low_power_mode_select);
    ret_req = handler_return && sleep_after_handler &&
              mode_ok(deep_sleep_select, low_power_mode_select);
    case (st_r.kind)
      stop1_pkg::ENTRY_WAIT_EVT: wake_now = st_r.sev ? (|irq_any_hit) : (|evt_hit);
      default: wake_now = |irq_en_hit;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = wake_line;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.load = 1'b0;
    st_nxt.entry_ignored = 1'b0;
    st_nxt.wake_done = 1'b0;
    st_nxt.service_irq = 1'b0;
    case (st_r.fsm)
      ST_RUN: begin
        if ((wfx_req || ret_req) && any_flag) begin
          st_nxt.entry_ignored = 1'b1;
        end else if (wfx_req || ret_req) begin
          st_nxt.fsm = ST_STOP;
          st_nxt.in_stop1 = 1'b1;
          st_nxt.core_clk_en = 1'b0;
          st_nxt.sev = pending_as_wake_event;
          if (ret_req && !wfx_req) begin
            st_nxt.kind = stop1_pkg::ENTRY_EXIT;
          end else if (wait_event_instr && !wait_interrupt_instr) begin
            st_nxt.kind = stop1_pkg::ENTRY_WAIT_EVT;
          end else begin
            st_nxt.kind = stop1_pkg::ENTRY_WAIT_INT;
          end
        end
      end
      ST_STOP: begin
        if (wake_now) begin
          st_nxt.fsm = ST_WAKE;
          st_nxt.load = 1'b1;
          st_nxt.irq_wake = |irq_en_hit;
        end
      end
      ST_WAKE: begin
        if (tmr_done) begin
          st_nxt.fsm = ST_RUN;
          st_nxt.in_stop1 = 1'b0;
          st_nxt.core_clk_en = 1'b1;
          st_nxt.wake_done = 1'b1;
          st_nxt.service_irq = st_r.irq_wake;
        end
      end
      default: st_nxt.fsm = ST_RUN;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r <= '0;
      st_r.fsm <= ST_RUN;
      st_r.kind <= stop1_pkg::ENTRY_WAIT_INT;
      st_r.core_clk_en <= 1'b1;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  stop1_wake_timer u_timer (
    .sys_clk(sys_clk),
    .srst(srst),
    .clk_en(clk_en),
    .load(st_r.load),
    .osc_sel_hsi(wake_osc_hsi),
    .done(tmr_done)
  );

  assign in_stop1 = st_r.in_stop1;
  assign core_clk_en = st_r.core_clk_en;
  assign entry_ignored = st_r.entry_ignored;
  assign wake_done = st_r.wake_done;
  assign service_irq = st_r.service_irq;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  AST_ENTRY_WAIT: assert property (
    clk_en && st_r.fsm == ST_RUN && wfx_req && !any_flag
    |=> in_stop1 && !core_clk_en)
    else $error("wait entry not taken");
  AST_MODE_GATE: assert property (
    clk_en && st_r.fsm == ST_RUN && !mode_ok(deep_sleep_select, low_power_mode_select)
    |=> !in_stop1)
    else $error("entry outside stop 1 mode");
  AST_ENTRY_RET: assert property (
    clk_en && st_r.fsm == ST_RUN && ret_req && !any_flag
    |=> in_stop1)
    else $error("handler return entry not taken");
  AST_RET_GATE: assert property (
    clk_en && st_r.fsm == ST_RUN && handler_return && !sleep_after_handler
    && !wait_interrupt_instr && !wait_event_instr |=> !in_stop1 && !entry_ignored)
    else $error("handler return entry without sleep after handler");
  AST_IGNORE: assert property (
    clk_en && st_r.fsm == ST_RUN && (wfx_req || ret_req) && any_flag
    |=> entry_ignored && !in_stop1)
    else $error("entry with pending flag");
  AST_WAKE_IRQ: assert property (
    clk_en && st_r.fsm == ST_STOP && st_r.kind != stop1_pkg::ENTRY_WAIT_EVT && (|irq_en_hit)
    |=> st_r.fsm == ST_WAKE)
    else $error("missed enabled irq wake");
  AST_EVT_ONLY: assert property (
    st_r.fsm == ST_STOP && st_r.kind == stop1_pkg::ENTRY_WAIT_EVT && !st_r.sev && !(|evt_hit)
    |=> st_r.fsm != ST_WAKE)
    else $error("event wait woke without event");
  AST_SEV_WAKE: assert property (
    clk_en && st_r.fsm == ST_STOP && st_r.kind == stop1_pkg::ENTRY_WAIT_EVT && st_r.sev
    && (|irq_any_hit) |=> st_r.fsm == ST_WAKE)
    else $error("pending as event wake missed");
  AST_LATENCY: assert property (
    st_r.load |-> ##[1:30] tmr_done)
    else $error("wake latency too long");
  AST_STOP_HOLD: assert property (
    clk_en && st_r.fsm == ST_STOP && !wake_now
    |=> in_stop1 && !core_clk_en && !wake_done)
    else $error("left stop without wake");
  AST_RESUME: assert property (
    clk_en && tmr_done && st_r.fsm == ST_WAKE
    |=> core_clk_en && wake_done && !in_stop1 && (service_irq == $past(st_r.irq_wake)))
    else $error("resume wrong");
  AST_SERVICE_PAIR: assert property (
    service_irq |-> wake_done && core_clk_en)
    else $error("irq service without resume");
  AST_RESUME_PULSE: assert property (
    clk_en && wake_done |=> !wake_done)
    else $error("resume pulse too long");
  AST_RUN_CLOCK: assert property (
    st_r.fsm == ST_RUN |-> !in_stop1 && core_clk_en)
    else $error("run state without core clock");
  AST_FREEZE: assert property (
    !clk_en |=> $stable(st_r))
    else $error("state moved while clock enable low");

  COV_ENTER: cover property (in_stop1 && !$past(in_stop1));
  COV_IGNORED: cover property (entry_ignored);
  COV_WAKE_IRQ: cover property (service_irq);
  COV_WAKE_EVT: cover property (wake_done && !service_irq);
  COV_SEV_WAKE: cover property (st_r.fsm == ST_STOP && st_r.sev && (|irq_any_hit)
    && !(|irq_en_hit));
endmodule : stop1_seq
`default_nettype wire

// [stop1_core_model.sv]
// core and wake-pin model facing the stop 1 sequencer
// assumes bench strobes last one cycle, driven just after the clock edge
`default_nettype none
module stop1_core_model (
  input wire logic go,
  input wire logic [1:0] kind,
  input wire logic core_clk_en,
  input wire logic [7:0] pins,
  output logic wait_int,
  output logic wait_evt,
  output logic hret,
  output logic [7:0] wake_line
);
  timeunit 1ns;
  timeprecision 1ns;
  // a halted core issues no instruction
  assign wait_int = go && core_clk_en && kind == 2'h0;
  assign wait_evt = go && core_clk_en && kind == 2'h1;
  assign hret = go && core_clk_en && kind == 2'h2;
  assign wake_line = pins;
endmodule : stop1_core_model
`default_nettype wire

// [stop1_seq_tb_top.sv]
// self-checking bench for the stop 1 sequencer
// assumes 10 MHz sys_clk, inputs driven 10 ns after each rising edge
`default_nettype none
module stop1_seq_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, srst = 1, ds = 0, sah = 0, sev = 0, hsi = 0, pf = 0, ip = 0, go = 0;
  logic en = 1;
  logic [2:0] mode_sel = 3'h1;
  logic [1:0] kind = 2'h0;
  logic [7:0] lp = 8'h00, im = 8'h00, em = 8'h00, ve = 8'h00, pins = 8'h00, wl;
  logic wait_int, wait_evt, hret, in_stop1, core_clk_en, entry_ignored, wake_done, service_irq;
  // wake line to resume: two sync flops, detect, timer load, resume
  localparam int unsigned PIPE_CYC = 5;
  int bad_count = 0, n_tests = 0;
  always #50 sys_clk = ~sys_clk;
  stop1_core_model i_core (.go(go), .kind(kind), .core_clk_en(core_clk_en), .pins(pins),
    .wait_int(wait_int), .wait_evt(wait_evt), .hret(hret), .wake_line(wl));
  stop1_seq i_dut (.sys_clk(sys_clk), .srst(srst), .clk_en(en), .wait_interrupt_instr(wait_int),
    .wait_event_instr(wait_evt), .handler_return(hret), .deep_sleep_select(ds),
    .sleep_after_handler(sah), .low_power_mode_select(mode_sel), .pending_as_wake_event(sev),
    .wake_osc_hsi(hsi), .line_pending_reg1(lp), .periph_wake_flags(pf), .irq_pending(ip),
    .wake_line(wl), .line_irq_mode(im), .line_evt_mode(em), .vector_enable(ve),
    .in_stop1(in_stop1), .core_clk_en(core_clk_en), .entry_ignored(entry_ignored),
    .wake_done(wake_done), .service_irq(service_irq));
  task automatic tally_and_finish;
    if (bad_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic got, input logic exp, input string what);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : check
  task automatic req(input logic [1:0] k);
    @(posedge sys_clk) #10 go = 1;
    kind = k;
    @(posedge sys_clk) #10 go = 0;
  endtask : req
  task automatic wake(input logic [7:0] p, input logic irq);
    int n;
    int unsigned lat;
    lat = hsi ? stop1_pkg::HSI_WAKE_CYC : stop1_pkg::MULTI_OSC_WAKE_CYC;
    if (stop1_pkg::REGFL_WAKE_CYC > lat) begin
      lat = stop1_pkg::REGFL_WAKE_CYC;
    end
    pins = p;
    for (n = 1; n <= 40; n++) begin
      @(posedge sys_clk) #10;
      if (wake_done === 1'b1) break;
    end
    if (n > 40) begin
      bad_count++;
      tally_and_finish();
    end else begin
      check(n == lat + PIPE_CYC, 1'b1, "latency");
      check(service_irq, irq, "service");
      check(in_stop1, 1'b0, "stop left");
      @(posedge sys_clk) #10 pins = 8'h00;
      check(core_clk_en, 1'b1, "clock back");
      check(wake_done, 1'b0, "resume pulse");
    end
  endtask : wake
  task automatic sc_wait_irq;
    ds = 1;
    im = 8'h01;
    ve = 8'h01;
    hsi = 1;
    req(2'h0);
    check(in_stop1, 1'b1, "wait entry");
    check(core_clk_en, 1'b0, "clock off");
    check(entry_ignored, 1'b0, "entry not ignored");
    wake(8'h01, 1'b1);
    hsi = 0;
  endtask : sc_wait_irq
  task automatic sc_refused;
    for (int i = 0; i < 3; i++) begin
      lp = (i == 0) ? 8'h04 : 8'h00;
      pf = (i == 1);
      ip = (i == 2);
      req(2'h0);
      check(entry_ignored, 1'b1, "ignored");
      check(in_stop1, 1'b0, "no entry");
    end
    {pf, ip, lp} = '0;
    mode_sel = 3'h2;
    req(2'h1);
    check(in_stop1, 1'b0, "wrong mode");
    check(entry_ignored, 1'b0, "wrong mode no pulse");
    mode_sel = 3'h1;
    en = 0;
    req(2'h0);
    check(in_stop1, 1'b0, "frozen no entry");
    en = 1;
    check(core_clk_en, 1'b1, "frozen clock kept");
  endtask : sc_refused
  task automatic sc_wait_evt;
    em = 8'h02;
    req(2'h1);
    check(in_stop1, 1'b1, "event wait entry");
    pins = 8'h01;
    repeat (30) @(posedge sys_clk);
    #10 check(in_stop1, 1'b1, "irq line ignored");
    wake(8'h02, 1'b0);
    sev = 1;
    ve = 8'h00;
    req(2'h1);
    wake(8'h01, 1'b0);
  endtask : sc_wait_evt
  task automatic sc_ret;
    ve = 8'h01;
    req(2'h2);
    check(in_stop1, 1'b0, "return without sleep after handler");
    sah = 1;
    ip = 1;
    req(2'h2);
    check(entry_ignored, 1'b1, "return with irq pending");
    ip = 0;
    req(2'h2);
    check(in_stop1, 1'b1, "return entry");
    wake(8'h01, 1'b1);
  endtask : sc_ret
  initial begin
    repeat (4) @(posedge sys_clk);
    #10 srst = 0;
    sc_wait_irq();
    sc_refused();
    sc_wait_evt();
    sc_ret();
    tally_and_finish();
  end
endmodule : stop1_seq_tb_top
`default_nettype wire
